/* core/epv_core.sv */
// How it works
// - After reset the stack top is fetched from vector entry 0 first.
// - Reset is position 1, rank -3, from power-up or warm reset pins.
// - At the first instruction the context drops to the base level.
// - Nonmaskable interrupt is position 2, rank -2, preempted only by reset.
// - Nonmaskable interrupt pends only from the software control write.
// - Hard fault, position 3, rank -1, catches blocked or disabled faults.
// - Memory protect mismatch pends position 4 at its settable priority.
// - Bus fault is position 5, settable, precise or imprecise.
// - Bus fault has a software enable; disabled faults escalate to hard fault.
// - Usage fault pends position 6 on undefined or illegal-state events.
// - Supervisor call instruction pends position 11 at settable priority.
// - Debug monitor pends only when enabled and not halting, whatever the current rank.
// - Deferred service request, position 14, pended by software only.
// - Tick timer expiry pends position 15 at settable priority.
// - Peripheral lines occupy positions 16 up, synchronised and prioritised.
// - Every settable priority resets to value 0.
// - GPIO ports A, B, C map to interrupt bits 0, 1, 2.
// - Remaining peripherals map to bits 3 to 28 as fixed.
// - Equal priority goes to the lower position number.
// - Eight selectable priority levels for settable exceptions and interrupts.
// - Settable level 0 ranks fourth, after reset, NMI and hard fault.

`default_nettype none

module epv_core (
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Reset request pins, active low, asynchronous
    input wire logic por_n_i,
    input wire logic warm_rst_n_i,
    // Boot handshake with the core
    input wire logic fetch_ack_i,
    input wire logic first_instr_i,
    // Software and core event strobes
    input wire logic nmi_set_i,
    input wire logic mem_fault_i,
    input wire logic bus_fault_precise_i,
    input wire logic bus_fault_imprecise_i,
    input wire logic usage_fault_i,
    input wire logic svc_exec_i,
    input wire logic dbg_mon_req_i,
    input wire logic dbg_mon_en_i,
    input wire logic halting_i,
    input wire logic deferred_service_request_set_i,
    input wire logic deferred_service_request_clr_i,
    input wire logic tick_expired_i,
    // Fault handler enables
    input wire logic mem_fault_en_i,
    input wire logic bus_fault_en_i,
    input wire logic usage_fault_en_i,
    // Priority write port
    input wire logic prio_wr_i,
    input wire logic [5:0] prio_pos_i,
    input wire logic [2:0] prio_val_i,
    // Interrupt enables per register bit
    input wire logic [28:0] irq_enable_i,
    // Peripheral interrupt lines, asynchronous
    input wire logic [4:0] gpio_irq_i,
    input wire logic [1:0] uart_irq_i,
    input wire logic sync_serial_port0_irq_i,
    input wire logic i2c0_irq_i,
    input wire logic pwm_fault_irq_i,
    input wire logic [2:0] pwm_gen_irq_i,
    input wire logic quadrature_decoder0_irq_i,
    input wire logic [3:0] conv_seq_irq_i,
    input wire logic watchdog_irq_i,
    input wire logic [5:0] timer_irq_i,
    input wire logic [2:0] comparator_irq_i,
    input wire logic sysctl_irq_i,
    // Activation handshake
    input wire logic take_i,
    input wire logic exc_return_i,
    input wire logic [5:0] ret_pos_i,
    // Outputs
    output logic fetch_req_o,
    output logic [5:0] fetch_idx_o,
    output logic in_reset_o,
    output logic pend_valid_o,
    output logic [5:0] pend_pos_o,
    output logic [3:0] pend_rank_o,
    output logic [3:0] cur_rank_o
);

    localparam int unsigned NE = epv_pkg::NUM_EXC;

    // Rank of a position given its settable level
    function automatic logic [3:0] rank_of(input logic [5:0] pos, input logic [2:0] lvl);
        logic [3:0] r;
        r = epv_pkg::RANK_SET_BASE + {1'b0, lvl};
        case (pos)
            epv_pkg::POS_RESET: r = epv_pkg::RANK_RESET;
            epv_pkg::POS_NMI: r = epv_pkg::RANK_NMI;
            epv_pkg::POS_HARD: r = epv_pkg::RANK_HARD;
            default: r = epv_pkg::RANK_SET_BASE + {1'b0, lvl};
        endcase
        return r;
    endfunction

    // Positions that may ever pend or activate
    function automatic logic pos_usable(input logic [5:0] pos);
        logic ok;
        ok = 1'b1;
        if (pos == epv_pkg::POS_STACK_TOP) begin
            ok = 1'b0;
        end
        if (pos >= epv_pkg::POS_RSV_LO && pos <= epv_pkg::POS_RSV_HI) begin
            ok = 1'b0;
        end
        if (pos == epv_pkg::POS_RSV_13 || pos >= 6'(NE)) begin
            ok = 1'b0;
        end
        return ok;
    endfunction

    // Settable positions
    function automatic logic pos_settable(input logic [5:0] pos);
        return pos_usable(pos) && pos > epv_pkg::POS_HARD;
    endfunction

    epv_pkg::epv_state_t state_q;
    logic [1:0] por_sync_q;
    logic [1:0] warm_sync_q;
    logic [28:0] irq_meta_q;
    logic [28:0] irq_sync_q;
    logic [28:0] irq_raw;
    logic [2:0] prio_q [NE];
    logic [NE-1:0] pend_q;
    logic [NE-1:0] active_q;
    logic [NE-1:0] pend_set;
    logic [NE-1:0] pend_clr;
    logic [NE-1:0] act_set;
    logic [NE-1:0] act_clr;
    logic restart;
    logic [3:0] cur_rank;
    logic best_valid;
    logic [5:0] best_pos;
    logic [3:0] best_rank;
    logic [3:0] mem_rank;
    logic [3:0] bus_rank;
    logic [3:0] usage_rank;
    logic [3:0] svc_rank;
    logic take_ok;

    // Map each peripheral line to its interrupt register bit
    always_comb begin
        irq_raw = '0;
        irq_raw[epv_pkg::IRQ_GPIO_A +: 5] = gpio_irq_i;
        irq_raw[epv_pkg::IRQ_UART0 +: 2] = uart_irq_i;
        irq_raw[epv_pkg::IRQ_SSP0] = sync_serial_port0_irq_i;
        irq_raw[epv_pkg::IRQ_I2C0] = i2c0_irq_i;
        irq_raw[epv_pkg::IRQ_PWM_FAULT] = pwm_fault_irq_i;
        irq_raw[epv_pkg::IRQ_PWM_GEN0 +: 3] = pwm_gen_irq_i;
        irq_raw[epv_pkg::IRQ_QDEC0] = quadrature_decoder0_irq_i;
        irq_raw[epv_pkg::IRQ_CONV_SEQ0 +: 4] = conv_seq_irq_i;
        irq_raw[epv_pkg::IRQ_WDOG] = watchdog_irq_i;
        irq_raw[epv_pkg::IRQ_TIMER0A +: 6] = timer_irq_i;
        irq_raw[epv_pkg::IRQ_ACMP0 +: 3] = comparator_irq_i;
        irq_raw[epv_pkg::IRQ_SYSCTL] = sysctl_irq_i;
    end

    // Two-stage synchronisers for pins
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            por_sync_q <= 2'h3;
            warm_sync_q <= 2'h3;
            irq_meta_q <= '0;
            irq_sync_q <= '0;
        end else begin
            por_sync_q <= {por_sync_q[0], por_n_i};
            warm_sync_q <= {warm_sync_q[0], warm_rst_n_i};
            irq_meta_q <= irq_raw;
            irq_sync_q <= irq_meta_q;
        end
    end

    // Power-up or warm reset request restarts the boot sequence
    assign restart = !por_sync_q[1] || !warm_sync_q[1];

    // Boot sequence: stack top, reset vector, then run
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            state_q <= epv_pkg::EPV_ST_SP_FETCH;
        end else if (restart) begin
            state_q <= epv_pkg::EPV_ST_SP_FETCH;
        end else begin
            case (state_q)
                epv_pkg::EPV_ST_SP_FETCH: begin
                    if (fetch_ack_i) begin
                        state_q <= epv_pkg::EPV_ST_VEC_FETCH;
                    end
                end
                epv_pkg::EPV_ST_VEC_FETCH: begin
                    if (fetch_ack_i) begin
                        state_q <= epv_pkg::EPV_ST_BOOT;
                    end
                end
                epv_pkg::EPV_ST_BOOT: begin
                    if (first_instr_i) begin
                        state_q <= epv_pkg::EPV_ST_RUN;
                    end
                end
                epv_pkg::EPV_ST_RUN: state_q <= epv_pkg::EPV_ST_RUN;
                default: state_q <= epv_pkg::EPV_ST_SP_FETCH;
            endcase
        end
    end

    // Priority table, eight levels per settable position
    always_ff @(posedge clk_i) begin
        if (!rst_n_i || restart) begin
            for (int i = 0; i < NE; i++) begin
                prio_q[i] <= epv_pkg::PRIO_RESET;
            end
        end else if (prio_wr_i && pos_settable(prio_pos_i)) begin
            prio_q[prio_pos_i] <= prio_val_i;
        end
    end

    // Current activation level: best rank among active positions
    always_comb begin
        cur_rank = epv_pkg::RANK_BASE_LEVEL;
        if (state_q != epv_pkg::EPV_ST_RUN) begin
            cur_rank = epv_pkg::RANK_RESET;
        end
        for (int i = 0; i < NE; i++) begin
            if (active_q[i] && rank_of(6'(i), prio_q[i]) < cur_rank) begin
                cur_rank = rank_of(6'(i), prio_q[i]);
            end
        end
    end

    // Event sources into pending bits, with fault escalation
    always_comb begin
        mem_rank = rank_of(epv_pkg::POS_MEM, prio_q[epv_pkg::POS_MEM]);
        bus_rank = rank_of(epv_pkg::POS_BUS, prio_q[epv_pkg::POS_BUS]);
        usage_rank = rank_of(epv_pkg::POS_USAGE, prio_q[epv_pkg::POS_USAGE]);
        svc_rank = rank_of(epv_pkg::POS_SVC, prio_q[epv_pkg::POS_SVC]);
        pend_set = '0;
        pend_set[epv_pkg::POS_NMI] = nmi_set_i;
        if (mem_fault_i) begin
            if (mem_fault_en_i && mem_rank < cur_rank) begin
                pend_set[epv_pkg::POS_MEM] = 1'b1;
            end else begin
                pend_set[epv_pkg::POS_HARD] = 1'b1;
            end
        end
        if (bus_fault_precise_i || bus_fault_imprecise_i) begin
            if (bus_fault_en_i && bus_rank < cur_rank) begin
                pend_set[epv_pkg::POS_BUS] = 1'b1;
            end else begin
                pend_set[epv_pkg::POS_HARD] = 1'b1;
            end
        end
        if (usage_fault_i) begin
            if (usage_fault_en_i && usage_rank < cur_rank) begin
                pend_set[epv_pkg::POS_USAGE] = 1'b1;
            end else begin
                pend_set[epv_pkg::POS_HARD] = 1'b1;
            end
        end
        if (svc_exec_i) begin
            if (svc_rank < cur_rank) begin
                pend_set[epv_pkg::POS_SVC] = 1'b1;
            end else begin
                pend_set[epv_pkg::POS_HARD] = 1'b1;
            end
        end
        pend_set[epv_pkg::POS_DBG] = dbg_mon_req_i && dbg_mon_en_i && !halting_i;
        pend_set[epv_pkg::POS_DEFERRED_SERVICE_REQUEST] = deferred_service_request_set_i;
        pend_set[epv_pkg::POS_TICK] = tick_expired_i;
        pend_set[NE-1:16] = irq_sync_q & irq_enable_i & epv_pkg::IRQ_ASSIGNED;
    end

    // Taking the offered exception clears its pending bit and activates it
    assign take_ok = take_i && pend_valid_o && pend_q[pend_pos_o];

    always_comb begin
        pend_clr = '0;
        act_set = '0;
        act_clr = '0;
        if (take_ok) begin
            pend_clr[pend_pos_o] = 1'b1;
            act_set[pend_pos_o] = 1'b1;
        end
        pend_clr[epv_pkg::POS_DEFERRED_SERVICE_REQUEST] = pend_clr[epv_pkg::POS_DEFERRED_SERVICE_REQUEST] || deferred_service_request_clr_i;
        if (exc_return_i && pos_usable(ret_pos_i)) begin
            act_clr[ret_pos_i] = 1'b1;
        end
    end

    // Pending bits; a new event wins over a clear in the same cycle
    always_ff @(posedge clk_i) begin
        if (!rst_n_i || restart || state_q != epv_pkg::EPV_ST_RUN) begin
            pend_q <= '0;
        end else begin
            pend_q <= (pend_q & ~pend_clr) | pend_set;
        end
    end

    // Active bits; return clears, new activation sets
    always_ff @(posedge clk_i) begin
        if (!rst_n_i || restart || state_q != epv_pkg::EPV_ST_RUN) begin
            active_q <= '0;
        end else begin
            active_q <= (active_q & ~act_clr) | act_set;
        end
    end

    // Arbitration: best rank that beats the current level, lowest position on a tie
    always_comb begin
        best_valid = 1'b0;
        best_pos = '0;
        best_rank = cur_rank;
        for (int i = 0; i < NE; i++) begin
            if (pend_q[i] && pos_usable(6'(i)) && rank_of(6'(i), prio_q[i]) < best_rank) begin
                best_valid = 1'b1;
                best_pos = 6'(i);
                best_rank = rank_of(6'(i), prio_q[i]);
            end
        end
    end

    // Registered offer to the core
    always_ff @(posedge clk_i) begin
        if (!rst_n_i || restart) begin
            pend_valid_o <= 1'b0;
            pend_pos_o <= '0;
            pend_rank_o <= epv_pkg::RANK_BASE_LEVEL;
        end else if (take_ok) begin
            pend_valid_o <= 1'b0;
            pend_pos_o <= pend_pos_o;
            pend_rank_o <= pend_rank_o;
        end else begin
            pend_valid_o <= best_valid && state_q == epv_pkg::EPV_ST_RUN;
            pend_pos_o <= best_pos;
            pend_rank_o <= best_rank;
        end
    end

    // Registered level and boot outputs
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            cur_rank_o <= epv_pkg::RANK_RESET;
            in_reset_o <= 1'b1;
            fetch_req_o <= 1'b0;
            fetch_idx_o <= epv_pkg::POS_STACK_TOP;
        end else begin
            cur_rank_o <= cur_rank;
            in_reset_o <= restart || state_q != epv_pkg::EPV_ST_RUN;
            fetch_req_o <= !restart && !fetch_ack_i &&
                           (state_q == epv_pkg::EPV_ST_SP_FETCH ||
                            state_q == epv_pkg::EPV_ST_VEC_FETCH);
            if (restart || state_q == epv_pkg::EPV_ST_SP_FETCH) begin
                fetch_idx_o <= epv_pkg::POS_STACK_TOP;
            end else begin
                fetch_idx_o <= epv_pkg::POS_RESET;
            end
        end
    end

endmodule

`default_nettype wire

/* core/epv_pkg.sv */
`default_nettype none

package epv_pkg;

    // Widths
    localparam int unsigned NUM_EXC = 45;
    localparam int unsigned NUM_IRQ = 29;
    localparam int unsigned POS_W = 6;
    localparam int unsigned PRIO_W = 3;
    localparam int unsigned RANK_W = 4;

    // Exception positions
    localparam logic [5:0] POS_STACK_TOP = 6'h00;
    localparam logic [5:0] POS_RESET = 6'h01;
    localparam logic [5:0] POS_NMI = 6'h02;
    localparam logic [5:0] POS_HARD = 6'h03;
    localparam logic [5:0] POS_MEM = 6'h04;
    localparam logic [5:0] POS_BUS = 6'h05;
    localparam logic [5:0] POS_USAGE = 6'h06;
    localparam logic [5:0] POS_RSV_LO = 6'h07;
    localparam logic [5:0] POS_RSV_HI = 6'h0A;
    localparam logic [5:0] POS_SVC = 6'h0B;
    localparam logic [5:0] POS_DBG = 6'h0C;
    localparam logic [5:0] POS_RSV_13 = 6'h0D;
    localparam logic [5:0] POS_DEFERRED_SERVICE_REQUEST = 6'h0E;
    localparam logic [5:0] POS_TICK = 6'h0F;
    localparam logic [5:0] POS_IRQ0 = 6'h10;

    // Internal ranks, lower wins; settable level p ranks at RANK_SET_BASE + p
    localparam logic [3:0] RANK_RESET = 4'h0;
    localparam logic [3:0] RANK_NMI = 4'h1;
    localparam logic [3:0] RANK_HARD = 4'h2;
    localparam logic [3:0] RANK_SET_BASE = 4'h3;
    localparam logic [3:0] RANK_BASE_LEVEL = 4'hB;

    // Value of every settable priority after reset
    localparam logic [2:0] PRIO_RESET = 3'h0;

    // Interrupt register bit of each peripheral source
    localparam int unsigned IRQ_GPIO_A = 0;
    localparam int unsigned IRQ_UART0 = 5;
    localparam int unsigned IRQ_SSP0 = 7;
    localparam int unsigned IRQ_I2C0 = 8;
    localparam int unsigned IRQ_PWM_FAULT = 9;
    localparam int unsigned IRQ_PWM_GEN0 = 10;
    localparam int unsigned IRQ_QDEC0 = 13;
    localparam int unsigned IRQ_CONV_SEQ0 = 14;
    localparam int unsigned IRQ_WDOG = 18;
    localparam int unsigned IRQ_TIMER0A = 19;
    localparam int unsigned IRQ_ACMP0 = 25;
    localparam int unsigned IRQ_SYSCTL = 28;
    localparam logic [28:0] IRQ_ASSIGNED = 29'h1FFFFFFF;

    // Reset and boot sequence
    typedef enum logic [1:0] {
        EPV_ST_SP_FETCH = 2'b00,
        EPV_ST_VEC_FETCH = 2'b01,
        EPV_ST_BOOT = 2'b10,
        EPV_ST_RUN = 2'b11
    } epv_state_t;

endpackage

`default_nettype wire

/* dv/epv_core_assertions.sv */
`default_nettype none

module epv_core_assertions (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic por_n_i,
    input wire logic warm_rst_n_i,
    input wire logic take_i,
    input wire logic fetch_req_o,
    input wire logic [5:0] fetch_idx_o,
    input wire logic in_reset_o,
    input wire logic pend_valid_o,
    input wire logic [5:0] pend_pos_o,
    input wire logic [3:0] pend_rank_o,
    input wire logic [3:0] cur_rank_o
);
    default clocking @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);

    // Offer accepted by the core
    sequence s_taken;
        take_i && pend_valid_o;
    endsequence

    // Boot order, restart and base level
    stack_first_a: assert property ($rose(rst_n_i) |=> fetch_req_o && fetch_idx_o == 6'h00)
        else $error("first fetch is not entry 0");
    restart_entry_a: assert property ($fell(por_n_i && warm_rst_n_i) |-> ##[1:6] in_reset_o)
        else $error("reset request did not restart");
    base_level_a: assert property ($fell(in_reset_o) |-> cur_rank_o == 4'hB)
        else $error("context not at base level");

    // Ranks of what is offered
    nmi_rank_a: assert property (pend_valid_o && pend_pos_o == 6'h02 |-> pend_rank_o == 4'h1)
        else $error("nmi rank wrong");
    hard_rank_a: assert property (pend_valid_o && pend_pos_o == 6'h03 |-> pend_rank_o == 4'h2)
        else $error("hard fault rank wrong");
    settable_rank_a: assert property (pend_valid_o && pend_pos_o > 6'h03 |->
        pend_rank_o inside {[4'h3:4'hA]})
        else $error("settable rank out of range");
    reserved_never_a: assert property (pend_valid_o |->
        !(pend_pos_o inside {[6'h07:6'h0A], 6'h0D}) && pend_pos_o < 6'h2D)
        else $error("reserved position offered");
    offer_better_a: assert property (pend_valid_o && $stable(cur_rank_o) |->
        pend_rank_o < cur_rank_o)
        else $error("offer not better than current");
    take_rank_a: assert property (s_taken |=> !pend_valid_o ##1
        cur_rank_o == $past(pend_rank_o, 2))
        else $error("taken rank not current");
endmodule

bind epv_core epv_core_assertions i_chk (
    .clk_i, .rst_n_i, .por_n_i, .warm_rst_n_i, .take_i, .fetch_req_o, .fetch_idx_o,
    .in_reset_o, .pend_valid_o, .pend_pos_o, .pend_rank_o, .cur_rank_o
);

`default_nettype wire

/* dv/epv_core_model.sv */
`default_nettype none

module epv_core_model (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic fetch_req_i,
    input wire logic [5:0] fetch_idx_i,
    input wire logic slow_i,
    output logic fetch_ack_o,
    output logic first_instr_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [5:0] idx_q;

    // Core side of boot: answers each fetch, then runs the first instruction
    initial begin
        fetch_ack_o = 1'b0;
        first_instr_o = 1'b0;
        idx_q = 6'h00;
        forever begin
            @(posedge clk_i);
            if (rst_n_i === 1'b1 && fetch_req_i === 1'b1) begin
                repeat (slow_i ? 3 : 0) @(posedge clk_i);
                idx_q = fetch_idx_i;
                fetch_ack_o <= 1'b1;
                @(posedge clk_i);
                fetch_ack_o <= 1'b0;
                while (fetch_req_i === 1'b1) @(posedge clk_i);
                if (idx_q == 6'h01) begin
                    first_instr_o <= 1'b1;
                    @(posedge clk_i);
                    first_instr_o <= 1'b0;
                end
            end
        end
    end
endmodule

`default_nettype wire

/* dv/epv_core_test.sv */
`default_nettype none

module epv_core_test;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [8:0][5:0] EV_POS = {6'h0F, 6'h0E, 6'h0C, 6'h0B, 6'h06, 6'h05, 6'h05,
        6'h04, 6'h02};
    logic clk_i, rst_n_i, por_n_i, warm_rst_n_i, fetch_ack_i, first_instr_i, slow;
    logic dbg_mon_en_i, halting_i, deferred_service_request_clr_i, mem_fault_en_i, bus_fault_en_i;
    logic usage_fault_en_i, prio_wr_i, take_i, exc_return_i;
    logic fetch_req_o, in_reset_o, pend_valid_o;
    logic [5:0] prio_pos_i, ret_pos_i, fetch_idx_o, pend_pos_o;
    logic [2:0] prio_val_i;
    logic [3:0] pend_rank_o, cur_rank_o;
    logic [28:0] irq_enable_i, irq;
    logic [8:0] ev;
    int num_errors = 0;
    int num_checks = 0;

    epv_core i_dut (
        .clk_i, .rst_n_i, .por_n_i, .warm_rst_n_i, .fetch_ack_i, .first_instr_i,
        .nmi_set_i(ev[0]), .mem_fault_i(ev[1]), .bus_fault_precise_i(ev[2]),
        .bus_fault_imprecise_i(ev[3]), .usage_fault_i(ev[4]), .svc_exec_i(ev[5]),
        .dbg_mon_req_i(ev[6]), .dbg_mon_en_i, .halting_i, .deferred_service_request_set_i(ev[7]),
        .deferred_service_request_clr_i, .tick_expired_i(ev[8]), .mem_fault_en_i, .bus_fault_en_i,
        .usage_fault_en_i, .prio_wr_i, .prio_pos_i, .prio_val_i, .irq_enable_i,
        .gpio_irq_i(irq[4:0]), .uart_irq_i(irq[6:5]), .sync_serial_port0_irq_i(irq[7]),
        .i2c0_irq_i(irq[8]), .pwm_fault_irq_i(irq[9]), .pwm_gen_irq_i(irq[12:10]),
        .quadrature_decoder0_irq_i(irq[13]), .conv_seq_irq_i(irq[17:14]),
        .watchdog_irq_i(irq[18]), .timer_irq_i(irq[24:19]), .comparator_irq_i(irq[27:25]),
        .sysctl_irq_i(irq[28]), .take_i, .exc_return_i, .ret_pos_i, .fetch_req_o,
        .fetch_idx_o, .in_reset_o, .pend_valid_o, .pend_pos_o, .pend_rank_o, .cur_rank_o
    );
    epv_core_model i_core (
        .clk_i, .rst_n_i, .fetch_req_i(fetch_req_o), .fetch_idx_i(fetch_idx_o),
        .slow_i(slow), .fetch_ack_o(fetch_ack_i), .first_instr_o(first_instr_i)
    );

    // 125 MHz clock
    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end

    task automatic cyc(input int n);
        repeat (n) @(negedge clk_i);
    endtask

    task automatic ck(input string name, input logic [5:0] exp, input logic [5:0] got);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic pulse(input logic [8:0] m);
        ev = m;
        cyc(1);
        ev = 9'h000;
    endtask

    task automatic prio(input logic [5:0] p, input logic [2:0] v);
        prio_wr_i = 1'b1;
        prio_pos_i = p;
        prio_val_i = v;
        cyc(1);
        prio_wr_i = 1'b0;
        cyc(1);
    endtask

    // Wait for an offer, check it, take it and check the new current rank
    task automatic offer(input logic [5:0] pos, input logic [3:0] rank);
        int n;
        n = 0;
        while (pend_valid_o !== 1'b1 && n < 20) begin
            cyc(1);
            n++;
        end
        ck("pend_valid_o", 6'h01, {5'h00, pend_valid_o});
        ck("pend_pos_o", pos, pend_pos_o);
        ck("pend_rank_o", {2'h0, rank}, {2'h0, pend_rank_o});
        irq = 29'h0;
        cyc(4);
        take_i = 1'b1;
        cyc(1);
        take_i = 1'b0;
        cyc(2);
        ck("cur_rank_o", {2'h0, rank}, {2'h0, cur_rank_o});
    endtask

    task automatic ret(input logic [5:0] pos);
        exc_return_i = 1'b1;
        ret_pos_i = pos;
        cyc(1);
        exc_return_i = 1'b0;
        cyc(3);
    endtask

    task automatic none(input int n);
        repeat (n) begin
            cyc(1);
            ck("no offer", 6'h00, {5'h00, pend_valid_o});
        end
    endtask

    task automatic boot();
        int n;
        n = 0;
        while (in_reset_o !== 1'b0 && n < 60) begin
            cyc(1);
            n++;
        end
        ck("base cur_rank_o", 6'h0B, {2'h0, cur_rank_o});
    endtask

    task automatic t_reset_boot();
        ck("in_reset_o", 6'h01, {5'h00, in_reset_o});
        ck("reset pend_rank_o", 6'h0B, {2'h0, pend_rank_o});
        rst_n_i = 1'b1;
        cyc(2);
        ck("fetch_req_o", 6'h01, {5'h00, fetch_req_o});
        ck("fetch_idx_o", 6'h00, fetch_idx_o);
        boot();
        slow = 1'b0;
    endtask

    task automatic t_events();
        for (int i = 0; i < 9; i++) begin
            pulse(9'h001 << i);
            offer(EV_POS[i], (i == 0) ? 4'h1 : 4'h3);
            ret(EV_POS[i]);
        end
        // Every configurable fault with its handler disabled escalates
        {mem_fault_en_i, bus_fault_en_i, usage_fault_en_i} = 3'h0;
        for (int i = 1; i < 5; i++) begin
            pulse(9'h001 << i);
            offer(6'h03, 4'h2);
            ret(6'h03);
        end
        {mem_fault_en_i, bus_fault_en_i, usage_fault_en_i} = 3'h7;
        dbg_mon_en_i = 1'b0;
        pulse(9'h040);
        none(8);
        dbg_mon_en_i = 1'b1;
        halting_i = 1'b1;
        pulse(9'h040);
        none(8);
        halting_i = 1'b0;
    endtask

    task automatic t_priority();
        prio(6'h0B, 3'h2);
        prio(6'h0F, 3'h2);
        prio(6'h02, 3'h7);
        pulse(9'h120);
        offer(6'h0B, 4'h5);
        none(6);
        pulse(9'h001);
        offer(6'h02, 4'h1);
        // Call blocked by the nonmaskable level goes to hard fault; deferred request cleared
        pulse(9'h0A0);
        deferred_service_request_clr_i = 1'b1;
        cyc(1);
        deferred_service_request_clr_i = 1'b0;
        ret(6'h02);
        offer(6'h03, 4'h2);
        ret(6'h03);
        none(4);
        ret(6'h0B);
        offer(6'h0F, 4'h5);
        ret(6'h0F);
        prio(6'h0F, 3'h7);
        pulse(9'h100);
        offer(6'h0F, 4'hA);
        ret(6'h0F);
    endtask

    task automatic t_irqs();
        for (int b = 0; b < 29; b++) begin
            irq = 29'h0000001 << b;
            offer(6'h10 + 6'(b), 4'h3);
            ret(6'h10 + 6'(b));
        end
        irq = 29'h0000003;
        offer(6'h10, 4'h3);
        ret(6'h10);
        offer(6'h11, 4'h3);
        ret(6'h11);
        irq_enable_i = 29'h1FFFFFF7;
        irq = 29'h0000008;
        none(8);
        irq = 29'h0;
        cyc(4);
        irq_enable_i = 29'h1FFFFFFF;
    endtask

    task automatic t_restart();
        for (int k = 0; k < 2; k++) begin
            por_n_i = (k != 0);
            warm_rst_n_i = (k == 0);
            cyc(4);
            ck("restart in_reset_o", 6'h01, {5'h00, in_reset_o});
            por_n_i = 1'b1;
            warm_rst_n_i = 1'b1;
            boot();
            pulse(9'h100);
            offer(6'h0F, 4'h3);
            ret(6'h0F);
        end
    endtask

    task automatic stop_test();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Watchdog against a hang
    initial begin
        repeat (8000) @(posedge clk_i);
        num_errors++;
        $display("[FAIL] watchdog expected done seen timeout");
        stop_test();
    end

    // Main sequence
    initial begin
        {rst_n_i, prio_wr_i, take_i, exc_return_i, halting_i, deferred_service_request_clr_i} = 6'h00;
        {por_n_i, warm_rst_n_i, slow, dbg_mon_en_i} = 4'hF;
        {mem_fault_en_i, bus_fault_en_i, usage_fault_en_i} = 3'h7;
        prio_pos_i = 6'h00;
        prio_val_i = 3'h0;
        ret_pos_i = 6'h00;
        irq_enable_i = 29'h1FFFFFFF;
        irq = 29'h0;
        ev = 9'h000;
        cyc(20);
        t_reset_boot();
        t_events();
        t_priority();
        t_irqs();
        t_restart();
        stop_test();
    end
endmodule

`default_nettype wire
